//--- shared/plr_pkg.sv
package plr_pkg;
	localparam int N_OMC = 16;
	localparam int N_IN = 64;
	localparam int N_PT = 10;
	localparam int N_PTS = 160;
	localparam int N_PIN = 19;
	localparam int N_DEC = 16;
	localparam int N_ONE = 13;
	localparam int N_CFG = 80;
	localparam int SYNC_W = 46;
	// runtime block offsets; port b, c, d sit at +0, +1, +2
	localparam logic [7:0] OFS_DIN = 8'h00;
	localparam logic [7:0] OFS_DOUT = 8'h04;
	localparam logic [7:0] OFS_DIR = 8'h08;
	localparam logic [7:0] OFS_MODE = 8'h0C;
	localparam logic [7:0] OFS_OMC_LO = 8'h10;
	localparam logic [7:0] OFS_OMC_HI = 8'h11;
	localparam logic [7:0] OFS_IMC_B = 8'h12;
	localparam logic [7:0] OFS_IMC_C = 8'h13;
	localparam logic [7:0] OFS_PAGE = 8'h14;
	localparam logic [7:0] OFS_PM0 = 8'h18;
	localparam logic [7:0] OFS_GATE0 = 8'h19;
	localparam logic [7:0] OFS_GATE1 = 8'h1A;
	localparam int PM0_SLOW_BIT = 3;
	localparam logic [7:0] RST_BYTE = 8'h00;
	// programming space: product-term masks below, configuration bytes above
	localparam logic [11:0] PROG_CFG_BASE = 12'hA00;
	localparam int CFG_DEC_HI = 0;
	localparam int CFG_DEC_PG = 16;
	localparam int CFG_DEC_CTL = 32;
	localparam int CFG_DEC_QIX = 48;
	localparam int CFG_OMC_REG = 64;
	localparam int CFG_IMC_REG = 66;
	localparam int CFG_IMC_LAT = 68;
	localparam int CFG_IMC_CLK = 70;
	localparam int CFG_WP_MAIN = 71;
	localparam int CFG_WP_SEC = 72;
	localparam int CFG_SECURE = 73;
	localparam int CFG_CS_EN = 74;
	localparam int CFG_JTAG_MUX = 75;
	localparam int DEC_VALID = 0;
	localparam int DEC_PG_CARE = 1;
	localparam int DEC_Q_EN = 2;
	localparam int DEC_Q_POL = 3;
	localparam int IDX_CSR = 12;
	localparam int PIN_C_LSB = 8;
	localparam int JT_TCK = 1;
	localparam int JT_TDI = 2;
	localparam logic [5:0] JT_OE_N = 6'h07;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} plr_rbus_s;

	typedef struct packed {
		logic [21:0] addr;
		logic wr_n;
		logic rd_n;
		logic boot_sel_n;
		logic mem_sel_n;
		logic io_space_strobe_n;
	} plr_dsp_s;

	typedef struct packed {
		logic [2:0] d;
		logic [7:0] c;
		logic [7:0] b;
	} plr_pins_s;

	typedef struct packed {
		logic active;
		logic we;
		logic re;
		logic erase;
		logic [11:0] addr;
		logic [7:0] wdata;
	} plr_prog_s;
endpackage

//--- core/plr_top.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// R01: decoder raises one select: main sector, secondary sector or control block.
// R02: decoder may drive external chip selects on port d pins.
// R03: logic array has 16 output cells and 16 input cells.
// R04: dsp loads and reads output cell flip-flops directly.
// R05: product terms see true and inverted forms of 64 inputs.
// R06: each output cell ors up to ten product terms.
// R07: output cell result is combinational or captured in its flip-flop.
// R08: output cell feeds back into array or drives a port b/c pin.
// R09: input cells clock, latch or pass pins; dsp reads them anytime.
// R10: 256-byte control block decoded, implemented registers for pins, power, cells.
// R11: control block reached via io space strobe, byte offsets from base.
// R12: 8-bit page register is dsp read/write and feeds both arrays.
// R13: each of 19 port pins is processor io or logic-array io.
// R14: processor io pins: dsp sets output state and reads input value.
// R15: jtag serves programming only, no boundary scan, bypass otherwise.
// R16: programming reaches whole device or parts without dsp help.
// R17: optional status and error pins on port c speed up programming.
// R18: slow bit set makes logic array hold outputs until inputs change.
// R19: two gate registers block chosen signals from entering the array.
// R20: security bit refuses programmer access; only full erase clears it (here reset clears it too).
// R21: per-sector write protect blocks dsp writes to that sector.
// R22: port c jtag pins act as general io when not programming (here only if CFG_JTAG_MUX bit 0 is set; while it is clear they stay jtag).
// R23: reset clears ports, page register and configuration registers.
module plr_top (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire plr_pkg::plr_rbus_s rbus,
	output logic [7:0] reg_rdata,
	input wire plr_pkg::plr_dsp_s dsp,
	output logic [7:0] main_sel,
	output logic [3:0] sec_sel,
	output logic csr_sel,
	output logic flash_wr_block,
	input wire plr_pkg::plr_pins_s pin_i,
	output var plr_pkg::plr_pins_s pin_o,
	output var plr_pkg::plr_pins_s pin_oe_n,
	input wire plr_pkg::plr_prog_s prog,
	output logic [7:0] prog_rdata,
	output logic prog_refused
);
	localparam int NP = plr_pkg::N_PTS;

	// three-stage sampling; a bit moves only when stages two and three agree
	logic [plr_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, sv_q;
	wire [plr_pkg::SYNC_W-1:0] s_raw = {dsp, pin_i};
	wire [plr_pkg::SYNC_W-1:0] s_dif = s2_q ^ s3_q;
	wire [plr_pkg::SYNC_W-1:0] sv_d = (~s_dif & s3_q) | (s_dif & sv_q);
	plr_pkg::plr_dsp_s dsp_s;
	plr_pkg::plr_pins_s pin_s;
	assign {dsp_s, pin_s} = sv_q;
	wire [18:0] pin_f = pin_s;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			sv_q <= '0;
		end else begin
			s1_q <= s_raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
			sv_q <= sv_d;
		end
	end

	// runtime control block
	logic [7:0] dout_q [3];
	logic [7:0] dir_q [3];
	logic [7:0] mode_q [3];
	logic [7:0] page_q, pm0_q, gate0_q, gate1_q, rdata_q;
	logic [15:0] omc_q;
	wire [7:0] ra = rbus.addr;
	wire [2:0] we_dout, we_dir, we_mode;
	for (genvar p = 0; p < 3; p++) begin : g_we
		assign we_dout[p] = rbus.wr && ra == plr_pkg::OFS_DOUT + 8'(p); // R14
		assign we_dir[p] = rbus.wr && ra == plr_pkg::OFS_DIR + 8'(p);
		assign we_mode[p] = rbus.wr && ra == plr_pkg::OFS_MODE + 8'(p); // R13
	end
	wire we_page = rbus.wr && ra == plr_pkg::OFS_PAGE; // R12
	wire we_pm0 = rbus.wr && ra == plr_pkg::OFS_PM0; // R18
	wire we_g0 = rbus.wr && ra == plr_pkg::OFS_GATE0; // R19
	wire we_g1 = rbus.wr && ra == plr_pkg::OFS_GATE1; // R19
	wire we_olo = rbus.wr && ra == plr_pkg::OFS_OMC_LO; // R04
	wire we_ohi = rbus.wr && ra == plr_pkg::OFS_OMC_HI; // R04
	wire [18:0] dout_f = {dout_q[2][2:0], dout_q[1], dout_q[0]};
	wire [18:0] dir_f = {dir_q[2][2:0], dir_q[1], dir_q[0]};
	wire [18:0] mode_f = {mode_q[2][2:0], mode_q[1], mode_q[0]};

	// configuration store, written only by the programmer
	logic [127:0] pt_q [NP];
	logic [7:0] cfg_q [plr_pkg::N_CFG];

	// logic array inputs: dsp strobes, low address, page, cell feedback, port d, input cells
	logic [15:0] imc_out, omc_out, sop, sop_eff, hold_q, imc_q;
	logic [63:0] in_raw, in_g, last_q;
	wire [4:0] ctl5 = {dsp_s.wr_n, dsp_s.rd_n, dsp_s.boot_sel_n, dsp_s.mem_sel_n,
		dsp_s.io_space_strobe_n};
	// feedback comes from the flip-flops only, so the array never forms a loop
	assign in_raw = {ctl5, dsp_s.addr[15:0], page_q, omc_q, pin_f[18:16], imc_out}; // R08 R12
	wire [15:0] gate_f = {gate1_q, gate0_q};
	for (genvar i = 0; i < plr_pkg::N_IN; i++) begin : g_gate
		assign in_g[i] = in_raw[i] & ~gate_f[i / 4]; // R19
	end

	// and array: an all-zero mask marks an unused term
	wire [127:0] lit = {~in_g, in_g}; // R05
	wire [NP-1:0] pt_v;
	for (genvar k = 0; k < NP; k++) begin : g_pt
		assign pt_v[k] = (|pt_q[k]) & (&(~pt_q[k] | lit));
	end
	for (genvar i = 0; i < plr_pkg::N_OMC; i++) begin : g_or
		assign sop[i] = |pt_v[i * plr_pkg::N_PT +: plr_pkg::N_PT]; // R03 R06
	end

	// slow mode re-evaluates one cycle after an input edge; that is the power trade
	wire slow = pm0_q[plr_pkg::PM0_SLOW_BIT];
	wire in_chg = in_g != last_q;
	wire [15:0] hold_d = (!slow || in_chg) ? sop : hold_q; // R18
	assign sop_eff = slow ? hold_q : sop; // R18

	// output cells
	wire [15:0] omc_reg_f = {cfg_q[plr_pkg::CFG_OMC_REG + 1], cfg_q[plr_pkg::CFG_OMC_REG]};
	wire [15:0] omc_seq = (omc_reg_f & sop_eff) | (~omc_reg_f & omc_q); // R07
	wire [15:0] omc_d = {we_ohi ? rbus.wdata : omc_seq[15:8],
		we_olo ? rbus.wdata : omc_seq[7:0]}; // R04
	assign omc_out = (omc_reg_f & omc_q) | (~omc_reg_f & sop_eff); // R07

	// input cells
	wire [15:0] imc_reg_f = {cfg_q[plr_pkg::CFG_IMC_REG + 1], cfg_q[plr_pkg::CFG_IMC_REG]};
	wire [15:0] imc_lat_f = {cfg_q[plr_pkg::CFG_IMC_LAT + 1], cfg_q[plr_pkg::CFG_IMC_LAT]};
	wire imc_ck = in_g[cfg_q[plr_pkg::CFG_IMC_CLK][5:0]];
	logic ck_prev_q;
	wire ck_rise = imc_ck & ~ck_prev_q;
	wire [15:0] imc_ld = imc_reg_f & ((imc_lat_f & {16{imc_ck}}) | (~imc_lat_f & {16{ck_rise}}));
	wire [15:0] imc_d = (imc_ld & pin_f[15:0]) | (~imc_ld & imc_q); // R09
	assign imc_out = (imc_reg_f & imc_q) | (~imc_reg_f & pin_f[15:0]); // R09

	// address decode
	wire mem_stb = ~dsp_s.boot_sel_n | ~dsp_s.mem_sel_n;
	wire io_stb = ~dsp_s.io_space_strobe_n;
	wire [plr_pkg::N_DEC-1:0] dec_raw;
	for (genvar j = 0; j < plr_pkg::N_DEC; j++) begin : g_dec
		wire [7:0] ctl = cfg_q[plr_pkg::CFG_DEC_CTL + j];
		wire [5:0] qx = cfg_q[plr_pkg::CFG_DEC_QIX + j][5:0];
		wire stb = (j < plr_pkg::IDX_CSR) ? mem_stb : ((j == plr_pkg::IDX_CSR) ? io_stb : // R11
			(mem_stb | io_stb));
		assign dec_raw[j] = ctl[plr_pkg::DEC_VALID] & stb
			& (dsp_s.addr[21:14] == cfg_q[plr_pkg::CFG_DEC_HI + j])
			& (!ctl[plr_pkg::DEC_PG_CARE] | (page_q == cfg_q[plr_pkg::CFG_DEC_PG + j]))
			& (!ctl[plr_pkg::DEC_Q_EN] | (in_g[qx] ^ ctl[plr_pkg::DEC_Q_POL])); // R01
	end
	// lowest matching entry wins so at most one internal select is raised
	wire [12:0] r13 = dec_raw[12:0];
	wire [12:0] sel13 = r13 & (~r13 + 13'h0001); // R01
	assign main_sel = sel13[7:0];
	assign sec_sel = sel13[11:8];
	assign csr_sel = sel13[plr_pkg::IDX_CSR]; // R10 R11
	wire [11:0] wp_f = {cfg_q[plr_pkg::CFG_WP_SEC][3:0], cfg_q[plr_pkg::CFG_WP_MAIN]};
	assign flash_wr_block = ~dsp_s.wr_n & (|(sel13[11:0] & wp_f)); // R21

	// programming port
	wire secure = cfg_q[plr_pkg::CFG_SECURE][0];
	wire p_ok = prog.active && !secure; // R20
	wire p_wr = prog.we && p_ok;
	wire p_rd = prog.re && p_ok;
	wire p_ers = prog.active && prog.erase; // R20
	wire p_ref = prog.active && (prog.we || prog.re) && secure; // R20
	wire p_is_cfg = prog.addr >= plr_pkg::PROG_CFG_BASE; // R16
	wire [11:0] coff = prog.addr - plr_pkg::PROG_CFG_BASE;
	wire cfg_ok = p_is_cfg && coff < 12'(plr_pkg::N_CFG);
	wire [6:0] cix = coff[6:0];
	wire [7:0] pt_ix = prog.addr[11:4];
	wire [6:0] pt_bit = {prog.addr[3:0], 3'h0};
	wire [7:0] cfg_rd = cfg_ok ? cfg_q[cix] : plr_pkg::RST_BYTE;
	wire [7:0] p_rval = p_is_cfg ? cfg_rd : pt_q[pt_ix][pt_bit +: 8];
	logic err_q, stat_q, prd_q;
	wire err_d = p_ref | (err_q & ~p_ers);

	// jtag: bypass bit only, shifted on sampled tck rising edges
	wire jtag_on = !cfg_q[plr_pkg::CFG_JTAG_MUX][0] || prog.active; // R22
	wire tck = pin_f[plr_pkg::PIN_C_LSB + plr_pkg::JT_TCK];
	wire tdi = pin_f[plr_pkg::PIN_C_LSB + plr_pkg::JT_TDI];
	logic tck_q, bypass_q;
	wire bypass_d = (jtag_on && tck && !tck_q) ? tdi : bypass_q; // R15

	// pins
	wire [2:0] cs_en = cfg_q[plr_pkg::CFG_CS_EN][2:0];
	wire [2:0] cs_d = (cs_en & ~dec_raw[15:13]) | (~cs_en & dout_f[18:16]); // R02
	wire [18:0] lg_out = {cs_d, omc_out}; // R08
	wire [18:0] po_a = (mode_f & lg_out) | (~mode_f & dout_f); // R13 R14
	wire [18:0] oe_a = ~dir_f;
	wire [5:0] jt_o = {err_q, stat_q, bypass_q, 3'h0}; // R17
	wire [18:0] po_f = jtag_on ? {po_a[18:14], jt_o, po_a[7:0]} : po_a; // R22
	wire [18:0] oe_f = jtag_on ? {oe_a[18:14], plr_pkg::JT_OE_N, oe_a[7:0]} : oe_a;
	assign pin_o = po_f;
	assign pin_oe_n = oe_f;

	// read selection; unmapped offsets read zero
	wire [7:0] rd_val =
		({8{ra == plr_pkg::OFS_DIN}} & pin_f[7:0]) | // R14
		({8{ra == plr_pkg::OFS_DIN + 8'h01}} & pin_f[15:8]) |
		({8{ra == plr_pkg::OFS_DIN + 8'h02}} & {5'h00, pin_f[18:16]}) |
		({8{ra == plr_pkg::OFS_DOUT}} & dout_q[0]) |
		({8{ra == plr_pkg::OFS_DOUT + 8'h01}} & dout_q[1]) |
		({8{ra == plr_pkg::OFS_DOUT + 8'h02}} & dout_q[2]) |
		({8{ra == plr_pkg::OFS_DIR}} & dir_q[0]) |
		({8{ra == plr_pkg::OFS_DIR + 8'h01}} & dir_q[1]) |
		({8{ra == plr_pkg::OFS_DIR + 8'h02}} & dir_q[2]) |
		({8{ra == plr_pkg::OFS_MODE}} & mode_q[0]) |
		({8{ra == plr_pkg::OFS_MODE + 8'h01}} & mode_q[1]) |
		({8{ra == plr_pkg::OFS_MODE + 8'h02}} & mode_q[2]) |
		({8{ra == plr_pkg::OFS_OMC_LO}} & omc_q[7:0]) | // R04
		({8{ra == plr_pkg::OFS_OMC_HI}} & omc_q[15:8]) |
		({8{ra == plr_pkg::OFS_IMC_B}} & imc_out[7:0]) | // R09
		({8{ra == plr_pkg::OFS_IMC_C}} & imc_out[15:8]) |
		({8{ra == plr_pkg::OFS_PAGE}} & page_q) | // R12
		({8{ra == plr_pkg::OFS_PM0}} & pm0_q) |
		({8{ra == plr_pkg::OFS_GATE0}} & gate0_q) |
		({8{ra == plr_pkg::OFS_GATE1}} & gate1_q); // R10
	assign reg_rdata = rdata_q;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int p = 0; p < 3; p++) begin
				dout_q[p] <= plr_pkg::RST_BYTE; // R23
				dir_q[p] <= plr_pkg::RST_BYTE;
				mode_q[p] <= plr_pkg::RST_BYTE;
			end
			page_q <= plr_pkg::RST_BYTE; // R23
			pm0_q <= plr_pkg::RST_BYTE;
			gate0_q <= plr_pkg::RST_BYTE;
			gate1_q <= plr_pkg::RST_BYTE;
			rdata_q <= plr_pkg::RST_BYTE;
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (we_dout[p]) dout_q[p] <= rbus.wdata;
				if (we_dir[p]) dir_q[p] <= rbus.wdata;
				if (we_mode[p]) mode_q[p] <= rbus.wdata;
			end
			if (we_page) page_q <= rbus.wdata;
			if (we_pm0) pm0_q <= rbus.wdata;
			if (we_g0) gate0_q <= rbus.wdata;
			if (we_g1) gate1_q <= rbus.wdata;
			rdata_q <= rbus.rd ? rd_val : plr_pkg::RST_BYTE;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			omc_q <= '0;
			imc_q <= '0;
			hold_q <= '0;
			last_q <= '0;
			ck_prev_q <= 1'b0;
			tck_q <= 1'b0;
			bypass_q <= 1'b0;
		end else begin
			omc_q <= omc_d;
			imc_q <= imc_d;
			hold_q <= hold_d;
			last_q <= in_g;
			ck_prev_q <= imc_ck;
			tck_q <= tck;
			bypass_q <= bypass_d;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			err_q <= 1'b0;
			stat_q <= 1'b0;
			prd_q <= 1'b0;
			prog_rdata <= plr_pkg::RST_BYTE;
		end else begin
			err_q <= err_d; // R17 R20
			stat_q <= p_wr | p_rd | p_ers; // R17
			prd_q <= p_rd;
			prog_rdata <= p_rd ? p_rval : plr_pkg::RST_BYTE;
		end
	end
	assign prog_refused = err_q;

	// erase beats a write in the same cycle; erase and reset are the only ways out of security
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int k = 0; k < NP; k++) pt_q[k] <= '0; // R23
			for (int c = 0; c < plr_pkg::N_CFG; c++) cfg_q[c] <= plr_pkg::RST_BYTE;
		end else if (p_ers) begin
			for (int k = 0; k < NP; k++) pt_q[k] <= '0; // R20
			for (int c = 0; c < plr_pkg::N_CFG; c++) cfg_q[c] <= plr_pkg::RST_BYTE;
		end else if (p_wr) begin
			if (cfg_ok) cfg_q[cix] <= prog.wdata; // R16
			else if (!p_is_cfg) pt_q[pt_ix][pt_bit +: 8] <= prog.wdata; // R16
		end
	end
endmodule // plr_top
`default_nettype wire

//--- bench/plr_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module plr_prog_model (
	input wire logic ref_clk,
	input wire logic [7:0] prog_rdata,
	output var plr_pkg::plr_prog_s prog
);
	initial prog = '0;

	// one access per call, no processor involvement at all
	task automatic op(input logic we, input logic re, input logic er, input logic [11:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge ref_clk);
		prog <= '{active: 1'b1, we: we, re: re, erase: er, addr: a, wdata: d};
		@(posedge ref_clk);
		// released lines carry the inverse so a stale value never looks valid
		prog <= '{active: 1'b0, we: 1'b0, re: 1'b0, erase: 1'b0, addr: ~a, wdata: ~d};
		#1 q = prog_rdata;
	endtask
endmodule // plr_prog_model
`default_nettype wire

//--- bench/plr_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module plr_top_chk (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire plr_pkg::plr_rbus_s rbus,
	input wire logic [7:0] reg_rdata,
	input wire plr_pkg::plr_dsp_s dsp,
	input wire logic [7:0] main_sel,
	input wire logic [3:0] sec_sel,
	input wire logic csr_sel,
	input wire logic flash_wr_block,
	input wire plr_pkg::plr_prog_s prog,
	input wire logic [7:0] prog_rdata,
	input wire logic prog_refused
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	a_sel_one_hot: assert property ($onehot0({main_sel, sec_sel, csr_sel}))
		else $error("more than one select active");
	a_rdata_quiet: assert property (!$past(rbus.rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_page_back: assert property (rbus.wr && rbus.addr == plr_pkg::OFS_PAGE ##1
		rbus.rd && rbus.addr == plr_pkg::OFS_PAGE |=> reg_rdata == $past(rbus.wdata, 2))
		else $error("page register readback wrong");
	a_unmapped_zero: assert property ($past(rbus.rd) && $past(rbus.addr) > 8'h1A
		|-> reg_rdata == 8'h00)
		else $error("unmapped offset read nonzero");
	a_csr_strobe: assert property (csr_sel |-> !$past(dsp.io_space_strobe_n, 3)
		|| !$past(dsp.io_space_strobe_n, 4))
		else $error("control block select without io strobe");
	a_wp_needs_sel: assert property (flash_wr_block |-> (|main_sel) || (|sec_sel))
		else $error("write block without a selected sector");
	a_prog_quiet: assert property (!$past(prog.active && prog.re) |-> prog_rdata == 8'h00)
		else $error("programming read data outside its cycle");
	a_refused_hold: assert property (prog_refused && !(prog.active && prog.erase)
		|=> prog_refused)
		else $error("refused flag dropped without erase");
	a_refused_cause: assert property ($rose(prog_refused)
		|-> $past(prog.active && (prog.we || prog.re)))
		else $error("refused flag raised without access");
endmodule // plr_top_chk

bind plr_top plr_top_chk plr_top_chk_i (.ref_clk(ref_clk), .arst_n(arst_n), .rbus(rbus),
	.reg_rdata(reg_rdata), .dsp(dsp), .main_sel(main_sel), .sec_sel(sec_sel), .csr_sel(csr_sel),
	.flash_wr_block(flash_wr_block), .prog(prog), .prog_rdata(prog_rdata),
	.prog_refused(prog_refused));
`default_nettype wire

//--- bench/plr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module plr_top_tb;
	logic ref_clk;
	logic arst_n;
	plr_pkg::plr_rbus_s rbus;
	logic [7:0] reg_rdata;
	plr_pkg::plr_dsp_s dsp;
	logic [7:0] main_sel;
	logic [3:0] sec_sel;
	logic csr_sel;
	logic flash_wr_block;
	wire plr_pkg::plr_pins_s pin_i;
	plr_pkg::plr_pins_s pin_o;
	plr_pkg::plr_pins_s pin_oe_n;
	plr_pkg::plr_prog_s prog;
	logic [7:0] prog_rdata;
	logic prog_refused;
	logic [18:0] ext;
	int fail_count;
	int check_count;
	int seed;
	logic [7:0] rv;
	logic [7:0] got;
	logic [7:0] ofs [16] = '{8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h0E,
		8'h14, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h7F, 8'hFF};
	localparam logic [18:0] OE_RST = {3'h7, 8'hC7, 8'hFF};

	// wire level: driven value where enabled, outside world elsewhere
	assign pin_i = (pin_o & ~pin_oe_n) | (ext & pin_oe_n);
	always #25 ref_clk = ~ref_clk;

	plr_top plr_top_i (.ref_clk(ref_clk), .arst_n(arst_n), .rbus(rbus), .reg_rdata(reg_rdata),
		.dsp(dsp), .main_sel(main_sel), .sec_sel(sec_sel), .csr_sel(csr_sel),
		.flash_wr_block(flash_wr_block), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
		.prog(prog), .prog_rdata(prog_rdata), .prog_refused(prog_refused));
	plr_prog_model plr_prog_model_i (.ref_clk(ref_clk), .prog_rdata(prog_rdata), .prog(prog));

	function automatic logic [7:0] rd_expect(input logic [7:0] a, input logic [7:0] w);
		rd_expect = (a <= 8'h1A) ? w : 8'h00;
	endfunction

	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] seen);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic check19(input string what, input logic [18:0] exp, input logic [18:0] seen);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		rbus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
	endtask

	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		rbus <= '{addr: a, wdata: rbus.wdata, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		rbus.rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic tick(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			rbus.wr <= 1'b0;
			rbus.rd <= 1'b0;
		end
	endtask

	task automatic pw(input logic [11:0] a, input logic [7:0] d);
		plr_prog_model_i.op(1'b1, 1'b0, 1'b0, a, d, got);
	endtask

	task automatic pr(input logic [11:0] a);
		plr_prog_model_i.op(1'b0, 1'b1, 1'b0, a, 8'h00, got);
	endtask

	initial begin
		ref_clk = 1'b0;
		arst_n = 1'b0;
		rbus = '0;
		dsp = '{addr: 22'h0, wr_n: 1'b1, rd_n: 1'b1, boot_sel_n: 1'b1, mem_sel_n: 1'b1,
			io_space_strobe_n: 1'b1};
		ext = '0;
		fail_count = 0;
		check_count = 0;
		seed = 39549;
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		#1 check19("oe after reset", OE_RST, pin_oe_n);
		foreach (ofs[i]) begin
			rv = $random(seed);
			reg_wr(ofs[i], rv);
			reg_rd(ofs[i], got);
			check8("register readback", rd_expect(ofs[i], rv), got);
		end
		reg_wr(plr_pkg::OFS_MODE, 8'h00);
		reg_wr(plr_pkg::OFS_DIR, 8'hFF);
		rv = $random(seed);
		reg_wr(plr_pkg::OFS_DOUT, rv);
		tick(2);
		check8("pin b drive", rv, pin_o.b);
		check8("pin b enable", 8'h00, pin_oe_n.b);
		reg_wr(plr_pkg::OFS_DIR, 8'h00);
		// port d was left driving by the random readback pass; release it before sampling
		reg_wr(plr_pkg::OFS_DIR + 8'h02, 8'h00);
		reg_wr(plr_pkg::OFS_MODE + 8'h02, 8'h00);
		rv = $random(seed);
		ext <= {3'h5, 8'h00, rv};
		tick(6);
		reg_rd(plr_pkg::OFS_DIN, got);
		check8("pin b input", rv, got);
		reg_rd(plr_pkg::OFS_DIN + 8'h02, got);
		check8("pin d input", 8'h05, got);
		// entry 0 claims a main sector, entry 12 the control block, main sector 0 protected
		pw(12'hA00, 8'h11);
		pw(12'hA20, 8'h01);
		pw(12'hA0C, 8'h22);
		pw(12'hA2C, 8'h01);
		pw(12'hA47, 8'h01);
		pr(12'hA0C);
		check8("cfg readback", 8'h22, got);
		dsp.addr <= {8'h22, 14'h0};
		dsp.io_space_strobe_n <= 1'b0;
		for (int k = 0; k < 10 && csr_sel !== 1'b1; k++) tick(1);
		if (csr_sel !== 1'b1) begin
			fail_count++;
			complete_run();
		end
		check8("control select", 8'h00, main_sel | {4'h0, sec_sel});
		dsp <= '{addr: {8'h11, 14'h0}, wr_n: 1'b0, rd_n: 1'b1, boot_sel_n: 1'b1,
			mem_sel_n: 1'b0, io_space_strobe_n: 1'b1};
		tick(6);
		check8("main select", 8'h01, main_sel);
		check8("write block", 8'h01, {7'h00, flash_wr_block});
		dsp.wr_n <= 1'b1;
		pw(12'hA49, 8'h01);
		pr(12'hA0C);
		check8("secure read", 8'h00, got);
		check8("refused set", 8'h01, {7'h00, prog_refused});
		plr_prog_model_i.op(1'b0, 1'b0, 1'b1, 12'h000, 8'h00, got);
		check8("refused clear", 8'h00, {7'h00, prog_refused});
		pr(12'hA0C);
		check8("erased cfg", 8'h00, got);
		reg_wr(plr_pkg::OFS_PAGE, 8'h5A);
		pw(12'hA0C, 8'h33);
		tick(1);
		arst_n <= 1'b0;
		tick(3);
		arst_n <= 1'b1;
		reg_rd(plr_pkg::OFS_PAGE, got);
		check8("page after reset", 8'h00, got);
		check19("oe after second reset", OE_RST, pin_oe_n);
		pr(12'hA0C);
		check8("cfg after reset", 8'h00, got);
		complete_run();
	end
endmodule // plr_top_tb
`default_nettype wire
